/* design/dcff_pkg.sv */
// Operation
// - 9-bit words, depth 512 or 2048
// - enabled write edge stores next word
// - one write per write edge, back to back
// - write refused while full, nothing changes
// - enabled read edge pops oldest word
// - active-low write enable; edge refreshes almost-full
// - active-low read enable; read edge updates emptiness
// - clocks may be common or independent
// - two flags encode one of four states
// - 00 empty, 10 1-16, 11 mid, 01 near full
// - master reset empties count and pointers
// - after reset flags low, read data low
// - same-edge opposite event excluded from flag
// - opposite event one cycle earlier included
// - every sync edge refreshes flag, data untouched

package dcff_pkg;

    // ************************************************************
    // widths and depths
    // ************************************************************
    localparam int              DATA_W          = 9;
    localparam int              ADDR_W          = 11;
    localparam int              PTR_W           = 12;
    localparam logic [PTR_W-1:0] DEPTH_SMALL    = 12'h200;
    localparam logic [PTR_W-1:0] DEPTH_LARGE    = 12'h800;
    localparam logic [PTR_W-1:0] WRAP_SMALL     = 12'h3FF;
    localparam logic [PTR_W-1:0] WRAP_LARGE     = 12'hFFF;
    localparam logic [ADDR_W-1:0] AMASK_SMALL   = 11'h1FF;
    localparam logic [ADDR_W-1:0] AMASK_LARGE   = 11'h7FF;
    localparam logic [PTR_W-1:0] AE_LIMIT       = 12'h010;
    localparam logic [PTR_W-1:0] AF_SMALL       = 12'h1F0;
    localparam logic [PTR_W-1:0] AF_LARGE       = 12'h7F0;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int               APB_AW         = 12;
    localparam logic [APB_AW-1:0] OFS_CTRL      = 12'h000;
    localparam logic [APB_AW-1:0] OFS_STAT      = 12'h004;
    localparam logic [APB_AW-1:0] OFS_IRQ       = 12'h008;
    localparam logic [APB_AW-1:0] OFS_MASK      = 12'h00C;
    localparam int               CTRL_DEPTH_BIT = 0;
    localparam int               STAT_FILL_LSB  = 0;
    localparam int               STAT_FLAG_LSB  = 16;
    localparam int               STAT_AF_BIT    = 18;
    localparam int               IRQ_W          = 4;
    localparam int               IRQ_OVF        = 0;
    localparam int               IRQ_UNF        = 1;
    localparam int               IRQ_AFULL      = 2;
    localparam int               IRQ_EMPTY      = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET      = 4'h0;
    localparam logic [31:0]      DATA_RESET     = 32'h0000_0000;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS          = 40;
    localparam int EXCLUDE_WINDOW_NS      = 0;
    localparam int INCLUDE_WINDOW_NS      = 12;
    localparam int RESET_PULSE_WIDTH_NS   = 12;
    localparam int RESET_RECOVERY_TIME_NS = 12;
    localparam int INCLUDE_CYCLES_RAW     = (INCLUDE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INCLUDE_CYCLES         = (INCLUDE_CYCLES_RAW < 1) ? 1 : INCLUDE_CYCLES_RAW;
    localparam int RESET_PULSE_CYCLES_RAW = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYCLES     = (RESET_PULSE_CYCLES_RAW < 1) ? 1 : RESET_PULSE_CYCLES_RAW;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        DCFF_LVL_EMPTY  = 2'b00,
        DCFF_LVL_ALMOST = 2'b01,
        DCFF_LVL_MID    = 2'b10
    } dcff_level_t;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dcff_memwr_t;

    typedef struct packed {
        logic              wrClkQ;
        logic              rdClkQ;
        logic [PTR_W-1:0]  wrPtr;
        logic [PTR_W-1:0]  rdPtr;
        logic [DATA_W-1:0] readData;
        dcff_level_t       level;
        logic              almostFull;
        logic              depthLarge;
        logic [IRQ_W-1:0]  irqStatus;
        logic [IRQ_W-1:0]  irqMask;
        logic [31:0]       prdata;
        logic              pslverr;
    } dcff_state_t;

endpackage

/* design/dcff_ram.sv */
`timescale 1ns/1ns
`default_nettype none

module dcff_ram (
    input  wire logic                          clk,     // system clock
    input  wire dcff_pkg::dcff_memwr_t         wr,      // write request
    input  wire logic [dcff_pkg::ADDR_W-1:0]   rdAddr,  // read address
    output logic      [dcff_pkg::DATA_W-1:0]   rdData   // word at read address
);

    // ************************************************************
    // storage, sized for the larger depth
    // ************************************************************
    logic [dcff_pkg::DATA_W-1:0] mem [0:(1 << dcff_pkg::ADDR_W)-1];

    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem[wr.addr] <= wr.data;
        end
    end

    assign rdData = mem[rdAddr];

endmodule // dcff_ram

`default_nettype wire

/* design/dcff_top.sv */
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module dcff_top (
    input  wire logic                        clk,          // system clock, 25 MHz
    input  wire logic                        rstn,         // async reset, active low
    input  wire logic                        psel,         // apb select
    input  wire logic                        penable,      // apb enable
    input  wire logic                        pwrite,       // apb direction
    input  wire logic [dcff_pkg::APB_AW-1:0] paddr,        // apb byte address
    input  wire logic [31:0]                 pwdata,       // apb write data
    output logic      [31:0]                 prdata,       // apb read data
    output logic                             pready,       // apb ready
    output logic                             pslverr,      // apb error
    output logic                             irq,          // level interrupt
    input  wire logic                        writeClock,   // sampled write clock
    input  wire logic                        writeEnableN, // write enable, low
    input  wire logic [dcff_pkg::DATA_W-1:0] writeData,    // write data
    input  wire logic                        readClock,    // sampled read clock
    input  wire logic                        readEnableN,  // read enable, low
    output logic      [dcff_pkg::DATA_W-1:0] readData,     // read data
    input  wire logic                        masterResetN, // master reset, low
    output logic                             flagBitOne,   // fill flag one
    output logic                             flagBitTwo    // fill flag two
);

    // ************************************************************
    // state and helpers
    // ************************************************************
    dcff_pkg::dcff_state_t              st;
    dcff_pkg::dcff_state_t              next_st;
    dcff_pkg::dcff_memwr_t              memWr;
    logic [dcff_pkg::ADDR_W-1:0]        memRdAddr;
    logic [dcff_pkg::DATA_W-1:0]        memRdData;
    logic [dcff_pkg::PTR_W-1:0]         wrap;
    logic [dcff_pkg::PTR_W-1:0]         depth;
    logic [dcff_pkg::PTR_W-1:0]         afThr;
    logic [dcff_pkg::ADDR_W-1:0]        addrMask;
    logic [dcff_pkg::PTR_W-1:0]         fill;
    logic [dcff_pkg::PTR_W-1:0]         rdFillAfter;
    logic [dcff_pkg::PTR_W-1:0]         wrFillAfter;
    logic                               wrEdge;
    logic                               rdEdge;
    logic                               wrAcc;
    logic                               rdAcc;
    logic                               isFull;
    logic                               isEmpty;
    logic [dcff_pkg::IRQ_W-1:0]         irqSet;
    logic [dcff_pkg::IRQ_W-1:0]         irqClr;
    logic                               apbSetup;
    logic                               apbWrite;
    dcff_pkg::dcff_level_t              rdLevel;

    dcff_ram u_ram (
        .clk    (clk),
        .wr     (memWr),
        .rdAddr (memRdAddr),
        .rdData (memRdData)
    );

    // ************************************************************
    // fill arithmetic and edge detection
    // ************************************************************
    always_comb begin
        wrap     = st.depthLarge ? dcff_pkg::WRAP_LARGE  : dcff_pkg::WRAP_SMALL;
        depth    = st.depthLarge ? dcff_pkg::DEPTH_LARGE : dcff_pkg::DEPTH_SMALL;
        afThr    = st.depthLarge ? dcff_pkg::AF_LARGE    : dcff_pkg::AF_SMALL;
        addrMask = st.depthLarge ? dcff_pkg::AMASK_LARGE : dcff_pkg::AMASK_SMALL;
        // fill from registered pointers: same-cycle events are not in it
        fill     = (st.wrPtr - st.rdPtr) & wrap;
        isFull   = (fill == depth);
        isEmpty  = (fill == '0);
        wrEdge   = writeClock & ~st.wrClkQ;
        rdEdge   = readClock & ~st.rdClkQ;
        wrAcc    = wrEdge & ~writeEnableN & ~isFull & masterResetN;
        rdAcc    = rdEdge & ~readEnableN & ~isEmpty & masterResetN;
        // each side sees the other's earlier events, never same-cycle ones
        rdFillAfter = fill - {{(dcff_pkg::PTR_W-1){1'b0}}, rdAcc};
        wrFillAfter = fill + {{(dcff_pkg::PTR_W-1){1'b0}}, wrAcc};
        if (rdFillAfter == '0) begin
            rdLevel = dcff_pkg::DCFF_LVL_EMPTY;
        end else if (rdFillAfter <= dcff_pkg::AE_LIMIT) begin
            rdLevel = dcff_pkg::DCFF_LVL_ALMOST;
        end else begin
            rdLevel = dcff_pkg::DCFF_LVL_MID;
        end
        memWr.en   = wrAcc;
        memWr.addr = st.wrPtr[dcff_pkg::ADDR_W-1:0] & addrMask;
        memWr.data = writeData;
        memRdAddr  = st.rdPtr[dcff_pkg::ADDR_W-1:0] & addrMask;
    end

    // ************************************************************
    // interrupt events and apb strobes
    // ************************************************************
    always_comb begin
        irqSet = '0;
        irqSet[dcff_pkg::IRQ_OVF]   = wrEdge & ~writeEnableN & isFull & masterResetN;
        irqSet[dcff_pkg::IRQ_UNF]   = rdEdge & ~readEnableN & isEmpty & masterResetN;
        irqSet[dcff_pkg::IRQ_AFULL] = wrEdge & masterResetN & ~st.almostFull
                                      & (wrFillAfter >= afThr);
        irqSet[dcff_pkg::IRQ_EMPTY] = rdEdge & masterResetN
                                      & (st.level != dcff_pkg::DCFF_LVL_EMPTY)
                                      & (rdLevel == dcff_pkg::DCFF_LVL_EMPTY);
        apbSetup = psel & ~penable;
        apbWrite = psel & penable & pwrite & ~st.pslverr;
        irqClr   = '0;
        if (apbWrite && paddr == dcff_pkg::OFS_IRQ) begin
            irqClr = pwdata[dcff_pkg::IRQ_W-1:0];
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st        = st;
        next_st.wrClkQ = writeClock;
        next_st.rdClkQ = readClock;
        if (wrAcc) begin
            next_st.wrPtr = (st.wrPtr + 12'h001) & wrap;
        end
        if (rdAcc) begin
            next_st.rdPtr    = (st.rdPtr + 12'h001) & wrap;
            next_st.readData = memRdData;
        end
        // any read edge refreshes emptiness, enabled or not
        if (rdEdge) begin
            next_st.level = rdLevel;
        end
        // any write edge refreshes almost-full, enabled or not
        if (wrEdge) begin
            next_st.almostFull = (wrFillAfter >= afThr);
        end
        if (!masterResetN) begin
            next_st.wrPtr      = '0;
            next_st.rdPtr      = '0;
            next_st.readData   = '0;
            next_st.level      = dcff_pkg::DCFF_LVL_EMPTY;
            next_st.almostFull = 1'b0;
        end
        // set wins over a same-cycle clear
        next_st.irqStatus = (st.irqStatus & ~irqClr) | irqSet;
        if (apbWrite && paddr == dcff_pkg::OFS_CTRL) begin
            next_st.depthLarge = pwdata[dcff_pkg::CTRL_DEPTH_BIT];
        end
        if (apbWrite && paddr == dcff_pkg::OFS_MASK) begin
            next_st.irqMask = pwdata[dcff_pkg::IRQ_W-1:0];
        end
        if (apbSetup) begin
            next_st.prdata  = dcff_pkg::DATA_RESET;
            next_st.pslverr = 1'b0;
            case (paddr)
                dcff_pkg::OFS_CTRL: begin
                    next_st.prdata[dcff_pkg::CTRL_DEPTH_BIT] = st.depthLarge;
                end
                dcff_pkg::OFS_STAT: begin
                    next_st.prdata[dcff_pkg::STAT_FILL_LSB +: dcff_pkg::PTR_W] = fill;
                    next_st.prdata[dcff_pkg::STAT_FLAG_LSB +: 2] = {flagBitOne, flagBitTwo};
                    next_st.prdata[dcff_pkg::STAT_AF_BIT] = st.almostFull;
                end
                dcff_pkg::OFS_IRQ: begin
                    next_st.prdata[dcff_pkg::IRQ_W-1:0] = st.irqStatus;
                end
                dcff_pkg::OFS_MASK: begin
                    next_st.prdata[dcff_pkg::IRQ_W-1:0] = st.irqMask;
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st            <= '0;
            st.level      <= dcff_pkg::DCFF_LVL_EMPTY;
            st.irqStatus  <= dcff_pkg::IRQ_RESET;
            st.irqMask    <= dcff_pkg::IRQ_RESET;
            st.prdata     <= dcff_pkg::DATA_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        // emptiness states take priority over a stale almost-full
        case (st.level)
            dcff_pkg::DCFF_LVL_EMPTY: begin
                flagBitOne = 1'b0;
                flagBitTwo = 1'b0;
            end
            dcff_pkg::DCFF_LVL_ALMOST: begin
                flagBitOne = 1'b1;
                flagBitTwo = 1'b0;
            end
            dcff_pkg::DCFF_LVL_MID: begin
                flagBitOne = ~st.almostFull;
                flagBitTwo = 1'b1;
            end
            default: begin
                flagBitOne = 1'b0;
                flagBitTwo = 1'b0;
            end
        endcase
    end

    assign readData = st.readData;
    assign prdata   = st.prdata;
    assign pslverr  = st.pslverr;
    assign pready   = psel & penable;
    assign irq      = |(st.irqStatus & st.irqMask);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence sWrOnly;
        wrAcc && !rdAcc;
    endsequence

    sequence sTwoWrites;
        sWrOnly ##1 !rdAcc ##1 sWrOnly;
    endsequence

    AST_WRITE_COUNTS: assert property (sWrOnly |=> fill == $past(fill) + 1)
        else $error("enabled write did not add one word");

    AST_BACK_TO_BACK: assert property (sTwoWrites |=> fill == $past(fill, 3) + 2)
        else $error("consecutive writes did not both land");

    AST_FULL_REFUSE: assert property (
        (wrEdge && !writeEnableN && isFull && !rdAcc && masterResetN)
        |=> (fill == $past(fill)) && (st.wrPtr == $past(st.wrPtr)))
        else $error("write while full changed the buffer");

    AST_READ_POPS: assert property (rdAcc |=> readData == $past(memRdData))
        else $error("read did not present oldest word");

    AST_EMPTY_HOLDS: assert property (
        (isEmpty && masterResetN) |=> readData == $past(readData))
        else $error("read data changed while empty");

    AST_EMPTY_FLAG: assert property (
        (rdEdge && masterResetN && rdFillAfter == '0) |=> !flagBitOne && !flagBitTwo)
        else $error("read edge at zero words did not show empty");

    AST_AFULL_FLAG: assert property (
        (wrEdge && masterResetN && wrFillAfter >= afThr) |=> st.almostFull)
        else $error("write edge missed almost-full");

    AST_MASTER_RESET: assert property (
        !masterResetN |=> fill == '0 && readData == '0 && !flagBitOne && !flagBitTwo)
        else $error("master reset did not empty the buffer");

    AST_REFRESH_ONLY: assert property (
        (rdEdge && readEnableN && masterResetN) |=> st.rdPtr == $past(st.rdPtr)
                                    && readData == $past(readData))
        else $error("flag refresh read moved data");

    AST_REFRESH_COUNT: assert property (
        (rdEdge && readEnableN && !wrAcc && masterResetN) |=> fill == $past(fill))
        else $error("flag refresh read changed the word count");

    AST_ALMOST_EMPTY_FLAG: assert property (
        (rdEdge && masterResetN && rdFillAfter != '0 && rdFillAfter <= dcff_pkg::AE_LIMIT)
        |=> flagBitOne && !flagBitTwo)
        else $error("read edge at 1 to 16 words did not show almost empty");

    AST_FILL_BOUND: assert property (fill <= depth)
        else $error("fill count beyond configured depth");

    AST_MR_DATA_LOW: assert property (
        $rose(masterResetN) |-> readData == '0 && !flagBitOne && !flagBitTwo)
        else $error("data or flags not low after master reset");

    AST_SAME_CYCLE_EXCLUDED: assert property (
        (rdEdge && wrAcc && !rdAcc && isEmpty && masterResetN) |=> !flagBitOne && !flagBitTwo)
        else $error("same-cycle write counted by read edge");

endmodule // dcff_top

`default_nettype wire

/* tb/dcff_peer.sv */
`timescale 1ns/1ns
`default_nettype none

module dcff_peer (
    input  wire logic                        clk,          // system clock
    input  wire logic                        slip,         // hold read clock one edge
    input  wire logic                        wrGo,         // start write burst
    input  wire logic                        rdGo,         // start read burst
    input  wire logic [15:0]                 burstLen,     // words in burst
    input  wire logic [dcff_pkg::DATA_W-1:0] firstWord,    // first written word
    input  wire logic [dcff_pkg::DATA_W-1:0] readData,     // fifo read data
    output logic                             writeClock,   // producer clock
    output logic                             writeEnableN, // write enable, low
    output logic      [dcff_pkg::DATA_W-1:0] writeData,    // write data
    output logic                             readClock,    // consumer clock
    output logic                             readEnableN,  // read enable, low
    output logic                             busy          // burst in flight
);
    logic [15:0]                 wrLeft   = 16'h0000;
    logic [15:0]                 rdLeft   = 16'h0000;
    logic [dcff_pkg::DATA_W-1:0] nextWord = 9'h000;
    logic [1:0]                  take     = 2'b00;
    logic [dcff_pkg::DATA_W-1:0] got [$];

    initial begin
        writeClock = 1'b0;
        readClock = 1'b1;
        writeEnableN = 1'b1;
        readEnableN = 1'b1;
        writeData = 9'h000;
    end
    assign busy = (wrLeft != 16'h0000) || (rdLeft != 16'h0000) || (take != 2'b00);

    // free-running clocks, opposite phase until a slip puts them in phase
    always @(posedge clk) begin
        writeClock <= ~writeClock;
        readClock <= slip ? readClock : ~readClock;
        take <= {take[0], 1'b0};
        if (take[1]) got.push_back(readData);
        if (wrGo) nextWord <= firstWord;
        if (wrGo) wrLeft <= burstLen;
        if (rdGo) rdLeft <= burstLen;
        if (!writeClock) begin
            writeEnableN <= (wrLeft == 16'h0000);
            writeData <= (wrLeft == 16'h0000) ? ~writeData : nextWord;
            if (wrLeft != 16'h0000) begin
                wrLeft <= wrLeft - 16'h0001;
                nextWord <= nextWord + 9'h001;
            end
        end
        if (!readClock) begin
            readEnableN <= (rdLeft == 16'h0000);
            take[0] <= (rdLeft != 16'h0000);
            if (rdLeft != 16'h0000) rdLeft <= rdLeft - 16'h0001;
        end
    end
endmodule // dcff_peer

`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        masterResetN = 1'b0;
    logic        wrGo = 1'b0;
    logic        rdGo = 1'b0;
    logic        slip = 1'b0;
    logic [15:0] burstLen = 16'h0000;
    logic [8:0]  firstWord = 9'h000;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, writeClock, writeEnableN, readClock, readEnableN;
    wire  [8:0]  writeData, readData;
    wire         flagBitOne, flagBitTwo, busy;
    logic [31:0] q;
    logic        e;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #20 clk = ~clk;

    dcff_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .writeClock(writeClock), .writeEnableN(writeEnableN),
        .writeData(writeData), .readClock(readClock), .readEnableN(readEnableN),
        .readData(readData), .masterResetN(masterResetN), .flagBitOne(flagBitOne),
        .flagBitTwo(flagBitTwo));
    dcff_peer peer (.clk(clk), .slip(slip), .wrGo(wrGo), .rdGo(rdGo), .burstLen(burstLen),
        .firstWord(firstWord), .readData(readData), .writeClock(writeClock),
        .writeEnableN(writeEnableN), .writeData(writeData), .readClock(readClock),
        .readEnableN(readEnableN), .busy(busy));

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer, result in q and e
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!(pready === 1'b1) && n < 20);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        if (n == 20) chk(32'h0, 32'h1, "pready missing");
    endtask

    task automatic burst(input logic w, input logic [15:0] len, input logic [8:0] first);
        int n;
        n = 0;
        @(posedge clk);
        {wrGo, rdGo, burstLen, firstWord} <= {w, ~w, len, first};
        @(posedge clk);
        {wrGo, rdGo} <= 2'b00;
        @(posedge clk);
        while (busy !== 1'b0 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
    endtask

    task automatic flags(input logic [1:0] exp);
        chk({30'h0, flagBitOne, flagBitTwo}, {30'h0, exp}, "flags");
    endtask

    task automatic mreset();
        @(posedge clk);
        masterResetN <= 1'b0;
        repeat (2) @(posedge clk);
        masterResetN <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset();
        flags(2'b00);
        chk({23'h0, readData}, 32'h0, "data after reset");
        apb(1'b0, dcff_pkg::OFS_MASK, 32'h0);
        chk(q, 32'h0, "mask reset");
        $display("test reset done");
    endtask

    task automatic t_level();
        peer.got.delete();
        burst(1'b1, 16'h0010, 9'h010);
        flags(2'b10);
        apb(1'b0, dcff_pkg::OFS_STAT, 32'h0);
        chk({20'h0, q[11:0]}, 32'h10, "fill");
        burst(1'b1, 16'h0001, 9'h020);
        flags(2'b11);
        burst(1'b0, 16'h0011, 9'h000);
        flags(2'b00);
        for (int i = 0; i < 17; i++) chk({23'h0, peer.got[i]}, 32'h10 + i, "order");
        $display("test level done");
    endtask

    task automatic t_full();
        peer.got.delete();
        apb(1'b1, dcff_pkg::OFS_MASK, 32'h1 << dcff_pkg::IRQ_OVF);
        burst(1'b1, 16'h01EF, 9'h000);
        flags(2'b11);
        burst(1'b1, 16'h0001, 9'h1EF);
        flags(2'b01);
        chk({31'h0, irq}, 32'h0, "irq before overflow");
        burst(1'b1, 16'h0013, 9'h1F0);
        chk({31'h0, irq}, 32'h1, "irq on overflow");
        apb(1'b1, dcff_pkg::OFS_IRQ, 32'h0000_000F);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        burst(1'b0, 16'h0200, 9'h000);
        for (int i = 0; i < 512; i++) chk({23'h0, peer.got[i]}, i, "full data");
        flags(2'b00);
        burst(1'b0, 16'h0001, 9'h000);
        chk({23'h0, readData}, 32'h1FF, "underflow hold");
        apb(1'b0, dcff_pkg::OFS_IRQ, 32'h0);
        chk({31'h0, q[dcff_pkg::IRQ_UNF]}, 32'h1, "underflow flag");
        chk({28'h0, q[3:0]}, (32'h1 << dcff_pkg::IRQ_UNF) | (32'h1 << dcff_pkg::IRQ_EMPTY),
            "irq status");
        $display("test full done");
    endtask

    task automatic t_mreset();
        @(posedge clk);
        slip <= 1'b1;
        @(posedge clk);
        slip <= 1'b0;
        burst(1'b1, 16'h0005, 9'h055);
        burst(1'b0, 16'h0001, 9'h000);
        chk({23'h0, readData}, 32'h55, "read before reset");
        mreset();
        flags(2'b00);
        chk({23'h0, readData}, 32'h0, "data after master reset");
        apb(1'b0, dcff_pkg::OFS_STAT, 32'h0);
        chk({20'h0, q[11:0]}, 32'h0, "fill after master reset");
        $display("test master reset done");
    endtask

    task automatic t_large();
        apb(1'b1, dcff_pkg::OFS_CTRL, 32'h1);
        apb(1'b0, dcff_pkg::OFS_CTRL, 32'h0);
        chk(q, 32'h1, "depth select");
        burst(1'b1, 16'h07EF, 9'h000);
        flags(2'b11);
        burst(1'b1, 16'h0001, 9'h000);
        flags(2'b01);
        apb(1'b0, dcff_pkg::OFS_STAT, 32'h0);
        chk(q, (32'h1 << dcff_pkg::STAT_AF_BIT) | (32'h1 << dcff_pkg::STAT_FLAG_LSB)
            | dcff_pkg::AF_LARGE, "stat at almost full");
        mreset();
        apb(1'b1, dcff_pkg::OFS_CTRL, 32'h0);
        $display("test large done");
    endtask

    task automatic t_apb();
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped error");
        chk(q, 32'h0, "unmapped data");
        $display("test apb done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        masterResetN <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_level();
        t_full();
        t_mreset();
        t_large();
        t_apb();
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire
